// ### design/eecc_pkg.sv
// Package: command codes, op classes, timing and status layout
package eecc_pkg;
  localparam logic [7:0] CMD_ERS_VFY_ALL = 8'h01;
  localparam logic [7:0] CMD_ERS_VFY_BLK = 8'h02;
  localparam logic [7:0] CMD_ERS_ALL = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK = 8'h09;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_ERS_VFY_SECT = 8'h10;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERS_SECTOR = 8'h12;
  localparam logic [7:0] CMD_PROT_OVERRIDE = 8'h13;
  // Register offsets on the plain register port
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_PARAM0 = 4'h1;
  localparam logic [3:0] REG_PARAM1 = 4'h2;
  localparam logic [3:0] REG_PARAM2 = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PROTECT = 4'h5;
  localparam logic [3:0] REG_MARGIN = 4'h6;
  localparam logic [3:0] REG_KEY = 4'h7;
  // Status fields
  localparam int ST_CCF = 7;
  localparam int ST_ACC = 5;
  localparam int ST_VFY_FAIL = 1;
  localparam int ST_ILLEGAL = 0;
  // Protect fields
  localparam int PR_PLOW = 0;
  localparam int PR_PHIGH = 1;
  localparam int PR_POPEN = 2;
  localparam int PR_EOPEN = 3;
  localparam int PR_OVERRIDE = 4;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [7:0] PROTECT_RST = 8'h00;
  localparam logic [7:0] KEY_RST = 8'h00;
  // Launch-to-array delay and array operation length, in ns
  localparam int SETUP_NS = 200;
  localparam int OP_NS = 2000;
  localparam int CLK_NS = 50;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int OP_CYC = (OP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] MARGIN_NORMAL = 2'h0;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_MREAD = 3'b010,
    OP_PROG = 3'b011,
    OP_SECT = 3'b100,
    OP_MASS = 3'b101
  } op_e;
endpackage

// ### design/eecc_arbiter.sv
// Concurrency arbiter for program-flash and EEPROM activity
`timescale 1ns/1ps
module eecc_arbiter
  import eecc_pkg::*;
(
  input wire op_e i_pf_op,
  input wire op_e i_ee_op,
  input wire logic i_pf_rd,
  input wire logic i_ee_rd,
  output logic o_allowed,
  output logic o_ee_grant
);
  // Allowed pairs; all else is a conflict
  always_comb begin
    o_allowed = 1'b1;
    if (i_pf_op != OP_NONE && i_ee_op != OP_NONE) begin
      o_allowed = 1'b0;
      if (i_pf_op == OP_READ && (i_ee_op == OP_READ ||
          i_ee_op == OP_MREAD || i_ee_op == OP_PROG ||
          i_ee_op == OP_SECT)) begin
        o_allowed = 1'b1;
      end
      if (i_pf_op == OP_MASS && i_ee_op == OP_MASS) begin
        o_allowed = 1'b1;
      end
    end
  end
  // One read per instant: EEPROM yields to program flash
  always_comb begin
    o_ee_grant = i_ee_rd && !i_pf_rd;
  end
endmodule

// ### design/eecc_timer.sv
// Down counter for launch setup and array operation phases
`timescale 1ns/1ps
module eecc_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [7:0] i_count,
  output logic o_done
);
  logic [7:0] cnt_r;
  logic run_r;
  // Count down; done pulses one cycle on reaching one
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
    end else if (i_ce) begin
      if (i_load) begin
        cnt_r <= i_count;
        run_r <= 1'b1;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          run_r <= 1'b0;
        end
      end
    end
  end
  // Load is left out here: it is decoded from done, and a load wins anyway
  assign o_done = i_ce && run_r && cnt_r == 8'h01;
endmodule

// ### design/eeprom_cmd_concurrency_ctrl.sv
// EEPROM command decode and flash/EEPROM concurrency control
`timescale 1ns/1ps
// Behaviour
// - Code 0x01 checks all EEPROM and program-flash blocks are erased.
// - Code 0x02 checks the selected EEPROM block is erased.
// - Code 0x08 erases all; needs all three pflash bits and eeprom open.
// - Code 0x09 erases a block; full EEPROM erase needs eeprom open.
// - Code 0x0B erases all blocks then verifies them, releasing security.
// - Code 0x0D sets user margin level for later EEPROM reads.
// - Code 0x0E sets field margin level, special mode only.
// - Code 0x10 verifies a word count from an address is erased.
// - Code 0x11 programs one to four EEPROM words; the code raises no o_array_prog when param_r[2][1:0] is 3.
// - Code 0x12 erases one addressed EEPROM sector.
// - Code 0x13 overrides protection after key matches.
// - Only pflash read with EEPROM read/margin/program/sector, mass/mass.
// - Disallowed simultaneous access reports illegal access exception.
// - Reads before array operation starts are permitted and valid.
// - Illegal indication only in the exact collision cycle.
// - One read per instant, arbitrated transparently.
// - Reads after non-normal margin setting count as margin reads.
// - Erase-all and erase-block count as mass erase.
// - Clearing complete flag launches; set again on completion.
// - Unsupported code sets access error; command not processed.
module eeprom_cmd_concurrency_ctrl
  import eecc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_mode,
  input wire logic i_pf_rd,
  input wire logic i_pf_busy,
  input wire logic i_pf_mass,
  input wire logic i_ee_rd,
  input wire logic [7:0] i_ee_rdata,
  input wire logic i_erased,
  output logic [7:0] o_rdata,
  output logic o_illegal,
  output logic o_ee_rd_valid,
  output logic [7:0] o_ee_data,
  output logic o_array_busy,
  output logic o_array_erase,
  output logic o_array_prog
);
  import eecc_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  // Array-side status arrives asynchronously; two flops each
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
    end else if (i_ce) begin
      pin_s1_r <= {i_special_mode, i_pf_busy, i_pf_mass, i_erased, 1'b0};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic special_s;
  logic pf_busy_s;
  logic pf_mass_s;
  logic erased_s;
  assign special_s = pin_s2_r[4];
  assign pf_busy_s = pin_s2_r[3];
  assign pf_mass_s = pin_s2_r[2];
  assign erased_s = pin_s2_r[1];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ARRAY = 3'b010,
    ST_VERIFY = 3'b011,
    ST_DONE = 3'b100
  } state_e;
  state_e state_r;
  logic [7:0] cmd_r;
  logic [7:0] param_r [3];
  logic [7:0] status_r;
  logic [7:0] protect_r;
  logic [1:0] margin_r;
  logic [7:0] key_r;
  logic launch;
  logic acc_err;
  logic setup_done;
  logic op_done;
  logic verify_phase_r;

  // Supported-code decode, used for the access-error check at launch
  function automatic logic cmd_known(input logic [7:0] c);
    case (c)
      CMD_ERS_VFY_ALL, CMD_ERS_VFY_BLK, CMD_ERS_ALL, CMD_ERS_BLK,
      CMD_UNSECURE, CMD_USER_MARGIN, CMD_FIELD_MARGIN,
      CMD_ERS_VFY_SECT, CMD_PROGRAM, CMD_ERS_SECTOR,
      CMD_PROT_OVERRIDE: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction

  // Protection gate checked at launch
  function automatic logic cmd_permitted(input logic [7:0] c,
                                         input logic [7:0] p,
                                         input logic sp);
    cmd_permitted = 1'b1;
    if (c == CMD_ERS_ALL) begin
      cmd_permitted = p[PR_PLOW] && p[PR_PHIGH] && p[PR_POPEN] &&
                      p[PR_EOPEN];
    end
    if (c == CMD_ERS_BLK) begin
      cmd_permitted = p[PR_EOPEN];
    end
    if (c == CMD_FIELD_MARGIN) begin
      cmd_permitted = sp;
    end
  endfunction

  // Launch when software writes 1 to the complete flag while idle
  assign launch = i_wr && i_addr == REG_STATUS && i_wdata[ST_CCF] &&
                  state_r == ST_IDLE && status_r[ST_CCF] &&
                  !status_r[ST_ACC];
  assign acc_err = launch && (!cmd_known(cmd_r) ||
                   !cmd_permitted(cmd_r, protect_r, special_s));

  // Command and parameter registers; frozen while busy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_r <= 8'h00;
      param_r[0] <= 8'h00;
      param_r[1] <= 8'h00;
      param_r[2] <= 8'h00;
    end else if (i_ce && i_wr && state_r == ST_IDLE) begin
      if (i_addr == REG_CMD) begin
        cmd_r <= i_wdata;
      end
      if (i_addr == REG_PARAM0) begin
        param_r[0] <= i_wdata;
      end
      if (i_addr == REG_PARAM1) begin
        param_r[1] <= i_wdata;
      end
      if (i_addr == REG_PARAM2) begin
        param_r[2] <= i_wdata;
      end
    end
  end

  // Key register; resets to KEY_RST, so a zero parameter matches the key with no write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_r <= KEY_RST;
    end else if (i_ce && i_wr && i_addr == REG_KEY) begin
      key_r <= i_wdata;
    end
  end

  // Protection: bits written by software, override bit set by 0x13
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      protect_r <= PROTECT_RST;
    end else if (i_ce) begin
      if (state_r == ST_DONE && cmd_r == CMD_PROT_OVERRIDE &&
          param_r[0] == key_r) begin
        protect_r <= protect_r | 8'h1f;
      end else if (i_wr && i_addr == REG_PROTECT) begin
        protect_r <= {3'h0, 1'b0, i_wdata[3:0]};
      end
    end
  end

  // Margin level, applied when a margin command completes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      margin_r <= MARGIN_NORMAL;
    end else if (i_ce && state_r == ST_DONE) begin
      if (cmd_r == CMD_USER_MARGIN || cmd_r == CMD_FIELD_MARGIN) begin
        margin_r <= param_r[0][1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic tmr_load;
  logic [7:0] tmr_count;
  logic no_array;
  assign no_array = cmd_r == CMD_USER_MARGIN ||
                    cmd_r == CMD_FIELD_MARGIN ||
                    cmd_r == CMD_PROT_OVERRIDE;
  assign tmr_load = i_ce && ((launch && !acc_err) ||
                    (state_r == ST_SETUP && setup_done) ||
                    (state_r == ST_ARRAY && op_done &&
                     cmd_r == CMD_UNSECURE && !verify_phase_r));
  assign tmr_count = (state_r == ST_IDLE) ? 8'(SETUP_CYC) : 8'(OP_CYC);

  eecc_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(op_done)
  );
  assign setup_done = op_done;

  // Idle -> setup window (reads valid) -> array -> done; 0x0D, 0x0E and 0x13 go from setup straight to done
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      verify_phase_r <= 1'b0;
    end else if (i_ce) begin
      unique case (state_r)
        ST_IDLE: begin
          verify_phase_r <= 1'b0;
          if (launch && !acc_err) begin
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (setup_done) begin
            state_r <= no_array ? ST_DONE : ST_ARRAY;
          end
        end
        ST_ARRAY: begin
          if (op_done) begin
            if (cmd_r == CMD_UNSECURE && !verify_phase_r) begin
              verify_phase_r <= 1'b1;
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Array strobes per command class
  logic is_erase;
  logic is_verify;
  assign is_erase = cmd_r == CMD_ERS_ALL || cmd_r == CMD_ERS_BLK ||
                    cmd_r == CMD_ERS_SECTOR ||
                    (cmd_r == CMD_UNSECURE && !verify_phase_r);
  assign is_verify = cmd_r == CMD_ERS_VFY_ALL || cmd_r == CMD_ERS_VFY_BLK ||
                     cmd_r == CMD_ERS_VFY_SECT ||
                     (cmd_r == CMD_UNSECURE && verify_phase_r);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_array_busy <= 1'b0;
      o_array_erase <= 1'b0;
      o_array_prog <= 1'b0;
    end else if (i_ce) begin
      o_array_busy <= state_r == ST_ARRAY;
      o_array_erase <= state_r == ST_ARRAY && is_erase;
      o_array_prog <= state_r == ST_ARRAY && cmd_r == CMD_PROGRAM &&
                      param_r[2][1:0] != 2'h3;
    end
  end

  // ------------------------------------------------------------
  // Concurrency
  // ------------------------------------------------------------
  op_e ee_op;
  op_e pf_op;
  logic allowed;
  logic ee_grant;
  always_comb begin
    ee_op = OP_NONE;
    if (state_r == ST_ARRAY) begin
      if (cmd_r == CMD_ERS_ALL || cmd_r == CMD_ERS_BLK) begin
        ee_op = OP_MASS;
      end else if (cmd_r == CMD_ERS_SECTOR) begin
        ee_op = OP_SECT;
      end else if (cmd_r == CMD_PROGRAM) begin
        ee_op = OP_PROG;
      end else begin
        ee_op = OP_MREAD;
      end
    end else if (i_ee_rd) begin
      ee_op = (margin_r != MARGIN_NORMAL) ? OP_MREAD : OP_READ;
    end
  end
  always_comb begin
    pf_op = OP_NONE;
    if (pf_mass_s) begin
      pf_op = OP_MASS;
    end else if (pf_busy_s) begin
      pf_op = OP_PROG;
    end else if (i_pf_rd) begin
      pf_op = OP_READ; // Margin level here governs EEPROM reads only
    end
  end

  eecc_arbiter u_arb (
    .i_pf_op(pf_op),
    .i_ee_op(ee_op),
    .i_pf_rd(i_pf_rd),
    .i_ee_rd(i_ee_rd),
    .o_allowed(allowed),
    .o_ee_grant(ee_grant)
  );

  logic collide;
  // Flag only when a read actually collides, not for the whole op
  assign collide = !allowed && (i_pf_rd || i_ee_rd);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_illegal <= 1'b0;
      o_ee_rd_valid <= 1'b0;
      o_ee_data <= 8'h00;
    end else if (i_ce) begin
      o_illegal <= collide;
      o_ee_rd_valid <= ee_grant && !collide &&
                       (state_r != ST_ARRAY || cmd_r != CMD_PROGRAM
                        || !i_ee_rd);
      o_ee_data <= i_ee_rdata;
    end
  end

  // Status: complete flag, access error, verify result, collision
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_r <= STATUS_RST;
    end else if (i_ce) begin
      if (i_wr && i_addr == REG_STATUS) begin
        if (i_wdata[ST_ACC]) begin
          status_r[ST_ACC] <= 1'b0;
        end
        if (i_wdata[ST_ILLEGAL]) begin
          status_r[ST_ILLEGAL] <= 1'b0;
        end
      end
      if (launch && !acc_err) begin
        status_r[ST_CCF] <= 1'b0;
        status_r[ST_VFY_FAIL] <= 1'b0;
      end
      if (acc_err) begin
        status_r[ST_ACC] <= 1'b1;
      end
      if (state_r == ST_ARRAY && op_done && is_verify && !erased_s) begin
        status_r[ST_VFY_FAIL] <= 1'b1;
      end
      if (collide) begin
        status_r[ST_ILLEGAL] <= 1'b1;
      end
      if (state_r == ST_DONE) begin
        status_r[ST_CCF] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        unique case (i_addr)
          REG_CMD: o_rdata <= cmd_r;
          REG_PARAM0: o_rdata <= param_r[0];
          REG_PARAM1: o_rdata <= param_r[1];
          REG_PARAM2: o_rdata <= param_r[2];
          REG_STATUS: o_rdata <= status_r;
          REG_PROTECT: o_rdata <= protect_r;
          REG_MARGIN: o_rdata <= {6'h00, margin_r};
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ### sim/eecc_ctrl_properties.sv
// Port-level assertions for the EEPROM command and concurrency controller
`timescale 1ns/1ps
module eecc_ctrl_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_mode,
  input wire logic i_pf_rd,
  input wire logic i_pf_busy,
  input wire logic i_pf_mass,
  input wire logic i_ee_rd,
  input wire logic [7:0] i_ee_rdata,
  input wire logic i_erased,
  input wire logic [7:0] o_rdata,
  input wire logic o_illegal,
  input wire logic o_ee_rd_valid,
  input wire logic [7:0] o_ee_data,
  input wire logic o_array_busy,
  input wire logic o_array_erase,
  input wire logic o_array_prog
);
  import eecc_pkg::*;
  logic [7:0] busy_cnt;
  // ----------------------------------------
  // Array phase length
  // ----------------------------------------
  // Counts enabled busy cycles; a low clock enable freezes the phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 8'h00;
    end else if (!o_array_busy) begin
      busy_cnt <= 8'h00;
    end else if (i_ce) begin
      busy_cnt <= busy_cnt + 8'h01;
    end
  end
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rdata_idle;
    $past(i_ce) && !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  property p_illegal_cause;
    o_illegal |-> $past(i_pf_rd) || $past(i_ee_rd);
  endproperty
  a_illegal_cause: assert property (p_illegal_cause) else $error("illegal without read");
  property p_ee_valid_cause;
    o_ee_rd_valid |-> $past(i_ee_rd);
  endproperty
  a_ee_valid_cause: assert property (p_ee_valid_cause) else $error("valid without read");
  property p_ee_valid_clean;
    o_ee_rd_valid |-> !o_illegal;
  endproperty
  a_ee_valid_clean: assert property (p_ee_valid_clean) else $error("colliding read valid");
  property p_ee_data;
    o_ee_rd_valid |-> o_ee_data == $past(i_ee_rdata);
  endproperty
  a_ee_data: assert property (p_ee_data) else $error("read data mismatch");
  property p_op_busy;
    o_array_erase || o_array_prog |-> o_array_busy;
  endproperty
  a_op_busy: assert property (p_op_busy) else $error("array op outside busy");
  property p_op_excl;
    !(o_array_erase && o_array_prog);
  endproperty
  a_op_excl: assert property (p_op_excl) else $error("erase and program together");
  property p_busy_len;
    $fell(o_array_busy) |-> busy_cnt == 8'(OP_CYC) || busy_cnt == 8'(2 * OP_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("array phase length wrong");
  property p_setup_gap;
    $rose(o_array_busy) |-> !$past(o_array_busy, 2) && !$past(o_array_busy, 3);
  endproperty
  a_setup_gap: assert property (p_setup_gap) else $error("no setup before array");
endmodule
bind eeprom_cmd_concurrency_ctrl eecc_ctrl_properties i_eecc_ctrl_properties (
  .i_clk, .i_rst_n, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .i_special_mode,
  .i_pf_rd, .i_pf_busy, .i_pf_mass, .i_ee_rd, .i_ee_rdata, .i_erased,
  .o_rdata, .o_illegal, .o_ee_rd_valid, .o_ee_data, .o_array_busy,
  .o_array_erase, .o_array_prog
);

// ### sim/eecc_array_model.sv
// Behavioural EEPROM array facing the controller
`timescale 1ns/1ps
module eecc_array_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ee_rd,
  input wire logic i_erase,
  input wire logic i_prog,
  output logic [7:0] o_ee_rdata,
  output logic o_erased
);
  logic [7:0] word_r;
  logic [7:0] last_r;
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Word steps per read; idle bus shows the last output inverted, so stale data returns every second idle cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_r <= 8'h3c;
      last_r <= 8'h00;
    end else begin
      word_r <= i_ee_rd ? word_r + 8'h11 : word_r;
      last_r <= o_ee_rdata;
    end
  end
  assign o_ee_rdata = i_ee_rd ? word_r : ~last_r;
  // Blank state follows the last erase or program of the array
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_erased <= 1'b1;
    end else if (i_erase) begin
      o_erased <= 1'b1;
    end else if (i_prog) begin
      o_erased <= 1'b0;
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the EEPROM command and concurrency controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  import eecc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_special_mode = 1'b0;
  logic i_pf_rd = 1'b0;
  logic i_pf_busy = 1'b0;
  logic i_pf_mass = 1'b0;
  logic i_ee_rd = 1'b0;
  logic [7:0] i_ee_rdata;
  logic i_erased;
  logic [7:0] o_rdata;
  logic [7:0] o_ee_data;
  logic o_illegal, o_ee_rd_valid, o_array_busy, o_array_erase, o_array_prog;
  logic saw_erase = 1'b0;
  logic saw_prog = 1'b0;
  logic ev;
  logic [7:0] st;
  logic [7:0] code;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 95443;
  logic [7:0] cmds [11] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0b, 8'h0d,
                            8'h0e, 8'h10, 8'h11, 8'h12, 8'h13};
  always #25 i_clk = ~i_clk;
  eecc_array_model i_eecc_array_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ee_rd(i_ee_rd), .i_erase(o_array_erase), .i_prog(o_array_prog),
    .o_ee_rdata(i_ee_rdata), .o_erased(i_erased));
  eeprom_cmd_concurrency_ctrl i_eeprom_cmd_concurrency_ctrl (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_special_mode(i_special_mode),
    .i_pf_rd(i_pf_rd), .i_pf_busy(i_pf_busy), .i_pf_mass(i_pf_mass),
    .i_ee_rd(i_ee_rd), .i_ee_rdata(i_ee_rdata), .i_erased(i_erased),
    .o_rdata(o_rdata), .o_illegal(o_illegal), .o_ee_rd_valid(o_ee_rd_valid),
    .o_ee_data(o_ee_data), .o_array_busy(o_array_busy),
    .o_array_erase(o_array_erase), .o_array_prog(o_array_prog));
  // Remember which array operations a command really started
  always @(posedge i_clk) begin
    saw_erase = saw_erase | (o_array_erase === 1'b1);
    saw_prog = saw_prog | (o_array_prog === 1'b1);
  end
  function automatic logic known(input logic [7:0] c);
    return c inside {cmds};
  endfunction
  // Erase in the upper bit, program in the lower
  function automatic logic [1:0] expect_op(input logic [7:0] c);
    return {c inside {8'h08, 8'h09, 8'h0b, 8'h12}, c == 8'h11};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic launch(input logic [7:0] c, input logic [7:0] p);
    saw_erase = 1'b0;
    saw_prog = 1'b0;
    wr(REG_CMD, c);
    wr(REG_PARAM0, p);
    wr(REG_STATUS, 8'h80);
  endtask
  // Polls the complete flag; a bounded loop so a stuck command cannot hang
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      rd(REG_STATUS, st);
      if (st[ST_CCF] === 1'b1) break;
    end
    if (st[ST_CCF] !== 1'b1) bad_count++; // Limit ran out
  endtask
  task automatic run(input logic [7:0] c, input logic [7:0] p);
    launch(c, p);
    wait_done();
  endtask
  task automatic wait_busy();
    for (int j = 0; j < 20 && o_array_busy !== 1'b1; j++) @(posedge i_clk);
    if (o_array_busy !== 1'b1) bad_count++; // Limit ran out
  endtask
  // One read cycle, then the one-cycle illegal pulse and its end
  task automatic pulse(input logic pf, input logic ee, input logic ex);
    @(posedge i_clk);
    i_pf_rd <= pf;
    i_ee_rd <= ee;
    @(posedge i_clk);
    i_pf_rd <= 1'b0;
    i_ee_rd <= 1'b0;
    #1 `CHK("illegal", ex, o_illegal)
    ev = o_ee_rd_valid;
    @(posedge i_clk);
    #1 `CHK("illegal end", 1'b0, o_illegal)
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Some 1000 cycles are needed; this limit leaves wide margin
  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(REG_STATUS, st);
    `CHK("status reset", STATUS_RST, st)
    rd(REG_PROTECT, st);
    `CHK("protect reset", PROTECT_RST, st)
    // Random codes outside the command set
    repeat (6) begin
      code = 8'($random(seed));
      if (known(code)) code = 8'hff;
      run(code, 8'($random(seed)));
      `CHK("bad code status", 8'ha0, st)
      `CHK("bad code op", 2'b00, {saw_erase, saw_prog})
      wr(REG_STATUS, 8'h20);
    end
    run(CMD_ERS_ALL, 8'h00);
    `CHK("locked erase all", 1'b1, st[ST_ACC])
    wr(REG_STATUS, 8'h20);
    run(CMD_FIELD_MARGIN, 8'h01);
    `CHK("field margin normal", 1'b1, st[ST_ACC])
    wr(REG_STATUS, 8'h20);
    wr(REG_KEY, 8'h5a);
    run(CMD_PROT_OVERRIDE, 8'h5a);
    rd(REG_PROTECT, st);
    `CHK("override", 5'h1f, st[4:0])
    i_special_mode <= 1'b1;
    repeat (4) @(posedge i_clk);
    // Every command once, now that protection and mode allow all
    foreach (cmds[k]) begin
      run(cmds[k], cmds[k] == 8'h13 ? 8'h5a : 8'($random(seed)));
      `CHK("accepted", 1'b0, st[ST_ACC])
      `CHK("op", expect_op(cmds[k]), {saw_erase, saw_prog})
    end
    run(CMD_ERS_SECTOR, 8'h00);
    run(CMD_ERS_VFY_SECT, 8'h04);
    `CHK("verify erased", 1'b0, st[ST_VFY_FAIL])
    run(CMD_PROGRAM, 8'h5a);
    run(CMD_ERS_VFY_SECT, 8'h04);
    `CHK("verify programmed", 1'b1, st[ST_VFY_FAIL])
    run(CMD_USER_MARGIN, 8'h01);
    pulse(1'b0, 1'b1, 1'b0);
    `CHK("ee read valid", 1'b1, ev)
    pulse(1'b1, 1'b1, 1'b0);
    i_pf_busy <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(1'b0, 1'b1, 1'b1);
    `CHK("collided read", 1'b0, ev)
    launch(CMD_ERS_SECTOR, 8'h00);
    pulse(1'b1, 1'b0, 1'b0);
    wait_busy();
    pulse(1'b1, 1'b0, 1'b1);
    `CHK("op continues", 1'b1, o_array_busy)
    i_pf_busy <= 1'b0;
    repeat (4) @(posedge i_clk);
    pulse(1'b1, 1'b0, 1'b0);
    wait_done();
    `CHK("illegal flag", 1'b1, st[ST_ILLEGAL])
    wr(REG_STATUS, 8'h01);
    launch(CMD_ERS_BLK, 8'h00);
    wait_busy();
    pulse(1'b1, 1'b0, 1'b1);
    // Freeze mid-operation; the phase length check counts enabled cycles
    @(posedge i_clk);
    i_ce <= 1'b0;
    repeat (12) @(posedge i_clk);
    `CHK("frozen busy", 1'b1, o_array_busy)
    i_ce <= 1'b1;
    i_pf_mass <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(1'b1, 1'b0, 1'b0);
    i_pf_mass <= 1'b0;
    wait_done();
    stop_test();
  end
endmodule
